// [rtl/csw_defines.vh]
/*
 constants for the context switch engine: descriptor fields, context image
 layout, status buffer layout, apb register map. no processes here.
*/
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH
`define CSW_PROXY_BIT 20
`define CSW_SWCID_HI 19
`define CSW_DESC_CID_LO 32
`define CSW_LCA_HI 31
`define CSW_LCA_LO 20
`define CSW_STAT_PAGE_BYTES 32'h0000_1000
`define CSW_LINE_BYTES 32'h0000_0040
`define CSW_RING_LINES 3'h5
`define CSW_ENG_LINES_DEF 8'h10
`define CSW_STATUS_LINES 3'h2
`define CSW_CSB_DW_OFS 8'h28
`define CSW_CSB_ENTRIES 4'hc
`define CSW_LAST_DW_OFS 8'h47
`define CSW_IDLE_CID 11'h7ff
`define CSW_QDEPTH 4
`define CSW_QPTR_W 2
`define CSW_RSN_W 4
`define CSW_RSN_IDLE_ACT 4'h0
`define CSW_RSN_COMPLETE 4'h1
`define CSW_RSN_WAIT 4'h2
`define CSW_RSN_PREEMPT 4'h3
`define CSW_RSN_FAULT 4'h4
`define CSW_RSN_ACT_IDLE 4'h5
`define CSW_SR_INHIBIT_BIT 0
`define CSW_A_CTRL 12'h000
`define CSW_A_MASK 12'h004
`define CSW_A_DESC_LO 12'h008
`define CSW_A_DESC_HI 12'h00c
`define CSW_A_SUBMIT 12'h010
`define CSW_A_STATUS 12'h014
`define CSW_A_GHSP 12'h018
`define CSW_A_CUR_CID 12'h01c
`define CSW_A_EVENT 12'h020
`define CSW_A_WAIT_ID 12'h024
`define CSW_A_ENG_LINES 12'h028
`define CSW_EV_COMPLETE 0
`define CSW_EV_WAIT 1
`define CSW_EV_FAULT 2
`define CSW_EV_PREEMPT 3
`define CSW_EV_WAKE 4
`endif

// [rtl/csw_queue.v]
/*
 in-order execution queue of submitted descriptors, flip-flop storage.
 assumes one clock; push ignored when full, pop ignored when empty.
*/
`timescale 1ns/10ps
`include "csw_defines.vh"
module csw_queue (
   input wire clk_in,
   input wire sys_rst_in,
   input wire flush_in,
   input wire push_in,
   input wire [63:0] push_data_in,
   input wire pop_in,
   output wire full_out,
   output wire empty_out,
   output wire [63:0] head_out
);
   reg [63:0] mem [0:`CSW_QDEPTH-1];
   reg [`CSW_QPTR_W-1:0] rd_ptr;
   reg [`CSW_QPTR_W-1:0] wr_ptr;
   reg [`CSW_QPTR_W:0] count;
   wire do_push;
   wire do_pop;
   genvar i;
   assign full_out = (count == `CSW_QDEPTH);
   assign empty_out = (count == 0);
   assign head_out = mem[rd_ptr];
   assign do_push = push_in & ~full_out;
   assign do_pop = pop_in & ~empty_out;
   generate
      for (i = 0; i < `CSW_QDEPTH; i = i + 1) begin : g_ent
         always @(posedge clk_in) begin
            if (sys_rst_in)
               mem[i] <= 64'h0;
            else if (do_push && wr_ptr == i)
               mem[i] <= push_data_in;
         end
      end
   endgenerate
   always @(posedge clk_in) begin
      if (sys_rst_in || flush_in) begin
         rd_ptr <= {`CSW_QPTR_W{1'b0}};
         wr_ptr <= {`CSW_QPTR_W{1'b0}};
         count <= {(`CSW_QPTR_W+1){1'b0}};
      end else begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (do_push && !do_pop)
            count <= count + 1'b1;
         else if (do_pop && !do_push)
            count <= count - 1'b1;
      end
   end
endmodule

// [rtl/csw_memport.v]
/*
 sequences one cacheline-granular memory operation: a run of line
 requests, each held until accepted. assumes memory answers with ack.
*/
`timescale 1ns/10ps
`include "csw_defines.vh"
module csw_memport (
   input wire clk_in,
   input wire sys_rst_in,
   input wire start_in,
   input wire [31:0] base_in,
   input wire [7:0] lines_in,
   input wire mem_ack_in,
   output reg mem_req_out,
   output reg [31:0] mem_addr_out,
   output wire busy_out,
   output wire done_out
);
   reg [7:0] left;
   reg done;
   assign busy_out = mem_req_out;
   assign done_out = done;
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         mem_req_out <= 1'b0;
         mem_addr_out <= 32'h0;
         left <= 8'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start_in && !mem_req_out) begin
            if (lines_in == 8'h0) begin
               done <= 1'b1;
            end else begin
               mem_req_out <= 1'b1;
               mem_addr_out <= base_in;
               left <= lines_in;
            end
         end else if (mem_req_out && mem_ack_in) begin
            if (left == 8'h1) begin
               mem_req_out <= 1'b0;
               done <= 1'b1;
            end
            left <= left - 8'h1;
            mem_addr_out <= mem_addr_out + `CSW_LINE_BYTES;
         end
      end
   end
endmodule

// [rtl/csw_engine.v]
/*
 context switch engine: apb register file, in-order proxy queue, context
 image save and restore sequencing, status buffer writes and switch
 interrupt. assumes an apb master on clk_in and a memory that acks lines
 and status writes; events and wait ids arrive as apb register writes on clk_in.
*/
`timescale 1ns/10ps
`include "csw_defines.vh"
// Functional notes
// - engine field selects engine on wait wake; code wakes when wait_id equals cur_desc[63:32]
// - proxy work runs strictly in arrival order
// - waiting proxy workload keeps head position
// - proxy page fault blocks others, idle allowed; code saves the proxy, goes idle, then runs the next queued descriptor
// - restore image on select, save on switch
// - address points at 4k status page first
// - first status lines used for auto reports
// - ring section follows page, five lines
// - restore ring first, then read control
// - engine section after ring, both directions
// - inhibit bit skips engine restore
// - valid switch-out reports 64-bit status word
// - sync and async switches are told apart
// - idle-to-active reported, id undefined
// - every report followed by switch interrupt
// - per reason mask of report and interrupt
// - status word holds id and reason
// - entries start at dword offset 28h
// - twelve entries, then wrap to first
// - last written offset at dword 47h
module csw_engine (
   input wire clk_in,
   input wire sys_rst_in,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire img_req_out,
   output wire [31:0] img_addr_out,
   output wire img_write_out,
   input wire img_ack_in,
   input wire [31:0] sr_ctl_in,
   output reg stat_req_out,
   output reg [31:0] stat_addr_out,
   output reg [63:0] stat_data_out,
   input wire stat_ack_in,
   output reg switch_irq_out
);
   localparam ST_IDLE = 4'h0;
   localparam ST_RING_RD = 4'h1;
   localparam ST_ENG_RD = 4'h2;
   localparam ST_RUN = 4'h3;
   localparam ST_RING_WR = 4'h4;
   localparam ST_ENG_WR = 4'h5;
   localparam ST_REPORT = 4'h6;
   localparam ST_LAST = 4'h7;
   localparam ST_IRQ = 4'h8;
   reg [3:0] state;
   reg [3:0] after_report;
   reg enable;
   reg [15:0] mask;
   reg [31:0] desc_lo;
   reg [31:0] desc_hi;
   reg [31:0] ghsp_base;
   reg [7:0] eng_lines;
   reg [63:0] cur_desc;
   reg cur_valid;
   reg inhibit;
   reg eng_valid;
   reg waiting;
   reg [3:0] pend_rsn;
   reg [10:0] pend_cid;
   reg [3:0] csb_idx;
   reg [31:0] event_reg;
   reg [31:0] wait_id;
   wire [3:0] rsn_sel;
   wire apb_wr;
   wire q_full;
   wire q_empty;
   wire [63:0] q_head;
   reg q_push;
   reg q_pop;
   reg mp_start;
   reg [31:0] mp_base;
   reg [7:0] mp_lines;
   wire mp_busy;
   wire mp_done;
   reg img_wr;
   wire proxy;
   wire [31:0] lca;
   wire [31:0] ring_base;
   wire [31:0] eng_base;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign apb_wr = psel & penable & pwrite;
   assign img_write_out = img_wr;
   assign proxy = cur_desc[`CSW_PROXY_BIT];
   // logical context address from descriptor low bits, same for proxy and non-proxy
   assign lca = proxy ? {cur_desc[`CSW_SWCID_HI:0], 12'h000} :
      {cur_desc[`CSW_SWCID_HI:0], 12'h000};
   assign ring_base = lca + `CSW_STAT_PAGE_BYTES;
   assign eng_base = ring_base + {24'h0, 5'h0, `CSW_RING_LINES} * `CSW_LINE_BYTES;
   assign rsn_sel = pend_rsn;
   csw_queue u_queue (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .flush_in(1'b0),
      .push_in(q_push),
      .push_data_in({desc_hi, desc_lo}),
      .pop_in(q_pop),
      .full_out(q_full),
      .empty_out(q_empty),
      .head_out(q_head)
   );
   csw_memport u_memport (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .start_in(mp_start),
      .base_in(mp_base),
      .lines_in(mp_lines),
      .mem_ack_in(img_ack_in),
      .mem_req_out(img_req_out),
      .mem_addr_out(img_addr_out),
      .busy_out(mp_busy),
      .done_out(mp_done)
   );
   always @* begin
      case (paddr)
         `CSW_A_CTRL: prdata = {31'h0, enable};
         `CSW_A_MASK: prdata = {16'h0, mask};
         `CSW_A_DESC_LO: prdata = desc_lo;
         `CSW_A_DESC_HI: prdata = desc_hi;
         `CSW_A_STATUS: prdata = {19'h0, eng_valid, csb_idx, q_full, q_empty, waiting,
            cur_valid, state};
         `CSW_A_GHSP: prdata = ghsp_base;
         `CSW_A_CUR_CID: prdata = cur_desc[63:32];
         `CSW_A_WAIT_ID: prdata = wait_id;
         `CSW_A_ENG_LINES: prdata = {24'h0, eng_lines};
         default: prdata = 32'h0;
      endcase
   end
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         enable <= 1'b0;
         mask <= 16'h0;
         desc_lo <= 32'h0;
         desc_hi <= 32'h0;
         ghsp_base <= 32'h0;
         eng_lines <= `CSW_ENG_LINES_DEF;
         wait_id <= 32'h0;
      end else if (apb_wr) begin
         case (paddr)
            `CSW_A_CTRL: enable <= pwdata[0];
            `CSW_A_MASK: mask <= pwdata[15:0];
            `CSW_A_DESC_LO: desc_lo <= pwdata;
            `CSW_A_DESC_HI: desc_hi <= pwdata;
            `CSW_A_GHSP: ghsp_base <= pwdata;
            `CSW_A_WAIT_ID: wait_id <= pwdata;
            `CSW_A_ENG_LINES: eng_lines <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   // submissions enter in arrival order
   always @* begin
      q_push = apb_wr && (paddr == `CSW_A_SUBMIT) && pwdata[0];
   end
   // events are one-cycle strobes written by software through the event register
   always @(posedge clk_in) begin
      if (sys_rst_in)
         event_reg <= 32'h0;
      else if (apb_wr && paddr == `CSW_A_EVENT)
         event_reg <= pwdata;
      else
         event_reg <= 32'h0;
   end
   always @* begin
      mp_start = 1'b0;
      mp_base = 32'h0;
      mp_lines = 8'h0;
      img_wr = 1'b0;
      q_pop = 1'b0;
      case (state)
         ST_IDLE: begin
            q_pop = enable && !q_empty && !mp_busy && !mp_done;
         end
         ST_RING_RD: begin
            mp_start = !mp_busy && !mp_done;
            mp_base = ring_base;
            mp_lines = {5'h0, `CSW_RING_LINES};
         end
         ST_ENG_RD: begin
            mp_start = !mp_busy && !mp_done;
            mp_base = eng_base;
            mp_lines = inhibit ? 8'h0 : eng_lines;
         end
         ST_RING_WR: begin
            mp_start = !mp_busy && !mp_done;
            mp_base = ring_base;
            mp_lines = {5'h0, `CSW_RING_LINES};
            img_wr = 1'b1;
         end
         ST_ENG_WR: begin
            mp_start = !mp_busy && !mp_done;
            mp_base = eng_base;
            mp_lines = eng_lines;
            img_wr = 1'b1;
         end
         default: ;
      endcase
   end
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         after_report <= ST_IDLE;
         cur_desc <= 64'h0;
         cur_valid <= 1'b0;
         inhibit <= 1'b0;
         eng_valid <= 1'b0;
         waiting <= 1'b0;
         pend_rsn <= `CSW_RSN_IDLE_ACT;
         pend_cid <= `CSW_IDLE_CID;
         csb_idx <= 4'h0;
         stat_req_out <= 1'b0;
         stat_addr_out <= 32'h0;
         stat_data_out <= 64'h0;
         switch_irq_out <= 1'b0;
      end else begin
         switch_irq_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (q_pop) begin
                  cur_desc <= q_head;
                  cur_valid <= 1'b1;
                  waiting <= 1'b0;
                  pend_rsn <= `CSW_RSN_IDLE_ACT;
                  pend_cid <= `CSW_IDLE_CID;
                  after_report <= ST_RING_RD;
                  state <= ST_REPORT;
               end
            end
            ST_RING_RD: begin
               if (mp_done) begin
                  inhibit <= sr_ctl_in[`CSW_SR_INHIBIT_BIT];
                  state <= ST_ENG_RD;
               end
            end
            ST_ENG_RD: begin
               if (mp_done) begin
                  eng_valid <= ~inhibit;
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (event_reg[`CSW_EV_WAKE] && !event_reg[`CSW_EV_WAIT] &&
                   wait_id == cur_desc[63:32]) begin
                  waiting <= 1'b0;
               end else if (event_reg[`CSW_EV_COMPLETE]) begin
                  pend_rsn <= `CSW_RSN_COMPLETE;
                  state <= ST_RING_WR;
               end else if (event_reg[`CSW_EV_PREEMPT]) begin
                  pend_rsn <= `CSW_RSN_PREEMPT;
                  state <= ST_RING_WR;
               end else if (event_reg[`CSW_EV_FAULT] && proxy) begin
                  pend_rsn <= `CSW_RSN_FAULT;
                  waiting <= 1'b1;
                  state <= ST_RING_WR;
               end else if (event_reg[`CSW_EV_WAIT] || event_reg[`CSW_EV_FAULT]) begin
                  waiting <= 1'b1;
               end
            end
            ST_RING_WR: begin
               if (mp_done)
                  state <= ST_ENG_WR;
            end
            ST_ENG_WR: begin
               if (mp_done) begin
                  eng_valid <= 1'b1;
                  pend_cid <= cur_desc[42:32];
                  cur_valid <= 1'b0;
                  after_report <= ST_IDLE;
                  state <= ST_REPORT;
               end
            end
            ST_REPORT: begin
               if (mask[rsn_sel]) begin
                  state <= after_report;
               end else if (!stat_req_out) begin
                  stat_req_out <= 1'b1;
                  stat_addr_out <= ghsp_base +
                     {22'h0, (`CSW_CSB_DW_OFS + {3'h0, csb_idx, 1'b0}), 2'h0};
                  stat_data_out <= {waiting, 15'h0, cur_desc[63:32] & 32'h0000_07ff,
                     pend_cid, 1'b0, pend_rsn};
               end else if (stat_ack_in) begin
                  stat_req_out <= 1'b0;
                  state <= ST_LAST;
               end
            end
            ST_LAST: begin
               if (!stat_req_out) begin
                  stat_req_out <= 1'b1;
                  stat_addr_out <= ghsp_base + {22'h0, `CSW_LAST_DW_OFS, 2'h0};
                  stat_data_out <= {60'h0, csb_idx};
               end else if (stat_ack_in) begin
                  stat_req_out <= 1'b0;
                  csb_idx <= (csb_idx == `CSW_CSB_ENTRIES - 4'h1) ? 4'h0 :
                     csb_idx + 4'h1;
                  state <= ST_IRQ;
               end
            end
            ST_IRQ: begin
               switch_irq_out <= 1'b1;
               state <= after_report;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// [bench/csw_engine_properties.sv]
/*
 concurrent checks on the ports of csw_engine.
 assumes one clock, clk_in, and a synchronous active-high sys_rst_in.
*/
`timescale 1ns/10ps
module csw_engine_properties (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic img_req_out,
   input wire logic [31:0] img_addr_out,
   input wire logic img_write_out,
   input wire logic img_ack_in,
   input wire logic stat_req_out,
   input wire logic [31:0] stat_addr_out,
   input wire logic [63:0] stat_data_out,
   input wire logic stat_ack_in,
   input wire logic switch_irq_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   property p_irq_pulse;
      switch_irq_out |=> !switch_irq_out;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
   property p_irq_after_ack;
      switch_irq_out |-> $past(stat_ack_in) || $past(stat_ack_in, 2) || $past(stat_ack_in, 3);
   endproperty
   a_irq_after_ack: assert property (p_irq_after_ack) else $error("irq without write");
   property p_irq_no_pend;
      switch_irq_out |-> !stat_req_out;
   endproperty
   a_irq_no_pend: assert property (p_irq_no_pend) else $error("irq with write pending");
   property p_report_irq;
      stat_req_out && stat_ack_in |-> ##[1:40] switch_irq_out;
   endproperty
   a_report_irq: assert property (p_report_irq) else $error("report without irq");
   property p_stat_hold;
      stat_req_out && !stat_ack_in |=> stat_req_out && $stable(stat_addr_out)
         && $stable(stat_data_out);
   endproperty
   a_stat_hold: assert property (p_stat_hold) else $error("status write dropped");
   property p_img_hold;
      img_req_out && !img_ack_in |=> img_req_out && $stable(img_addr_out)
         && $stable(img_write_out);
   endproperty
   a_img_hold: assert property (p_img_hold) else $error("image request dropped");
   property p_img_step;
      img_req_out && img_ack_in ##1 img_req_out && img_write_out == $past(img_write_out)
         |-> img_addr_out == $past(img_addr_out) + 32'h40;
   endproperty
   a_img_step: assert property (p_img_step) else $error("image line step wrong");
   property p_line_align;
      img_req_out |-> img_addr_out[5:0] == 6'h00;
   endproperty
   a_line_align: assert property (p_line_align) else $error("image line unaligned");
endmodule
bind csw_engine csw_engine_properties chk_u (.clk_in, .sys_rst_in, .img_req_out,
   .img_addr_out, .img_write_out, .img_ack_in, .stat_req_out, .stat_addr_out,
   .stat_data_out, .stat_ack_in, .switch_irq_out);

// [bench/csw_mem_model.sv]
/*
 memory partner: acks image lines and status writes after a short or long wait.
 assumes requests stay up until acked.
*/
`timescale 1ns/10ps
module csw_mem_model (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic slow_in,
   input wire logic inhibit_in,
   input wire logic img_req_in,
   input wire logic stat_req_in,
   output logic img_ack_out,
   output logic stat_ack_out,
   output wire logic [31:0] sr_ctl_out
);
   logic [2:0] img_wait;
   logic [2:0] stat_wait;
   assign sr_ctl_out = {31'h0, inhibit_in};
   always @(posedge clk_in) begin
      img_ack_out <= 1'b0;
      stat_ack_out <= 1'b0;
      if (sys_rst_in) begin
         img_wait <= 3'h0;
         stat_wait <= 3'h0;
      end else begin
         if (img_req_in && !img_ack_out) begin
            img_wait <= (img_wait >= {slow_in, 2'b00}) ? 3'h0 : img_wait + 3'h1;
            img_ack_out <= (img_wait >= {slow_in, 2'b00});
         end
         if (stat_req_in && !stat_ack_out) begin
            stat_wait <= (stat_wait >= {slow_in, 2'b00}) ? 3'h0 : stat_wait + 3'h1;
            stat_ack_out <= (stat_wait >= {slow_in, 2'b00});
         end
      end
   end
endmodule

// [bench/csw_engine_tb_top.sv]
/*
 bench for csw_engine: apb master and queue model of image and status traffic.
 assumes csw_mem_model answers the memory side.
*/
`timescale 1ns/10ps
`include "csw_defines.vh"
module csw_engine_tb_top;
   reg clk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, inh = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rd, ghsp, cid, lo;
   wire [31:0] prdata, img_addr_out, stat_addr_out, sr_ctl;
   wire [63:0] stat_data_out;
   wire pready, pslverr, img_req_out, img_write_out, img_ack, stat_req_out, stat_ack, irq;
   int errors = 0, checked = 0, cyc = 0, idx = 0, irq_exp = 0, irq_seen = 0, ev = 0;
   logic [3:0] exp_rsn;
   logic [32:0] exp_img[$];
   logic [31:0] exp_sa[$];
   logic [63:0] exp_sd[$], exp_sm[$], md;
   always #10 clk_in = ~clk_in;
   csw_engine dut_u (.clk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .img_req_out, .img_addr_out, .img_write_out,
      .img_ack_in(img_ack), .sr_ctl_in(sr_ctl), .stat_req_out, .stat_addr_out,
      .stat_data_out, .stat_ack_in(stat_ack), .switch_irq_out(irq));
   csw_mem_model mem_u (.clk_in, .sys_rst_in, .slow_in(slow), .inhibit_in(inh),
      .img_req_in(img_req_out), .stat_req_in(stat_req_out), .img_ack_out(img_ack),
      .stat_ack_out(stat_ack), .sr_ctl_out(sr_ctl));
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask
   task report(input logic [3:0] rsn, input logic [10:0] away);
      exp_sa.push_back(ghsp + 32'((`CSW_CSB_DW_OFS + 2 * idx) * 4));
      exp_sd.push_back({rsn == `CSW_RSN_FAULT, 47'h0, away, 1'b0, rsn});
      exp_sm.push_back(64'h8000_0000_0000_ffef);
      exp_sa.push_back(ghsp + 32'(`CSW_LAST_DW_OFS * 4));
      exp_sd.push_back(64'(idx));
      exp_sm.push_back('1);
      idx = (idx + 1) % `CSW_CSB_ENTRIES;
      irq_exp++;
   endtask
   task lines(input logic w, input logic eng);
      for (int k = 0; k < (eng ? 5 + `CSW_ENG_LINES_DEF : 5); k++)
         exp_img.push_back({w, {lo[19:0], 12'h000} + 32'h1000 + 32'(k) * 32'h40});
   endtask
   task drain;
      while (exp_img.size() || exp_sa.size()) @(posedge clk_in);
      repeat (8) @(posedge clk_in);
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         stop_test;
      end
      if (!sys_rst_in && img_req_out && img_ack)
         check("image line", {img_write_out, img_addr_out}, exp_img.size() ? exp_img.pop_front() : 'x);
      if (!sys_rst_in && stat_req_out && stat_ack) begin
         if (exp_sa.size() == 0) begin
            check("status write", 1'b1, 1'b0);
         end else begin
            md = exp_sm.pop_front();
            check("status addr", stat_addr_out, exp_sa.pop_front());
            check("status word", stat_data_out & md, exp_sd.pop_front() & md);
         end
      end
      if (irq === 1'b1)
         irq_seen++;
   end
   initial begin
      void'($urandom(32'hca5e));
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      ghsp = $urandom & 32'hffff_f000;
      apb(1'b1, `CSW_A_GHSP, ghsp);
      apb(1'b1, `CSW_A_CTRL, 32'h1);
      for (int i = 0; i < 7; i++) begin
         lo = {11'h0, i[0], 20'($urandom)};
         cid = $urandom;
         inh <= 1'($urandom);
         slow <= i[1];
         apb(1'b1, `CSW_A_MASK, (i == 3) ? 32'h2 : 32'h0);
         report(`CSW_RSN_IDLE_ACT, `CSW_IDLE_CID);
         lines(1'b0, !inh);
         apb(1'b1, `CSW_A_DESC_LO, lo);
         apb(1'b1, `CSW_A_DESC_HI, cid);
         apb(1'b1, `CSW_A_SUBMIT, 32'h1);
         drain;
         apb(1'b1, `CSW_A_EVENT, 32'h1 << `CSW_EV_WAIT);
         apb(1'b0, `CSW_A_STATUS, 32'h0);
         check("waiting set", rd[5], 1'b1);
         check("engine valid", rd[12], !inh);
         apb(1'b1, `CSW_A_WAIT_ID, cid);
         apb(1'b1, `CSW_A_EVENT, 32'h1 << `CSW_EV_WAKE);
         apb(1'b0, `CSW_A_CUR_CID, 32'h0);
         check("current id", rd, cid);
         apb(1'b0, `CSW_A_STATUS, 32'h0);
         check("waiting clear", rd[5], 1'b0);
         ev = (i == 1) ? `CSW_EV_FAULT : (i == 5) ? `CSW_EV_PREEMPT : `CSW_EV_COMPLETE;
         exp_rsn = (i == 1) ? `CSW_RSN_FAULT : (i == 5) ? `CSW_RSN_PREEMPT : `CSW_RSN_COMPLETE;
         lines(1'b1, 1'b1);
         if (i != 3)
            report(exp_rsn, cid[10:0]);
         apb(1'b1, `CSW_A_EVENT, 32'h1 << ev);
         drain;
      end
      check("irq count", irq_seen, irq_exp);
      apb(1'b1, 12'h030, 32'hffff_ffff);
      apb(1'b0, 12'h030, 32'h0);
      check("unmapped read", rd, 32'h0);
      stop_test;
   end
endmodule
